// ### src/ptm_params.svh
// Purpose: Constants for the paired 32-bit timer.
// Assumes: Control words are 16 bits wide.
// Notes:   Bit positions follow the control word layout.
`ifndef PTM_PARAMS_SVH
`define PTM_PARAMS_SVH

// ****************************************
// Control word fields
// ****************************************
`define PTM_BIT_ON        15
`define PTM_BIT_IDLE_STOP 13
`define PTM_BIT_GATE      6
`define PTM_BIT_PS_HI     5
`define PTM_BIT_PS_LO     4
`define PTM_BIT_WIDE      3
`define PTM_BIT_CLKSRC    1

// ****************************************
// Reset values and timing
// ****************************************
`define PTM_CTRL_RESET    16'h0000
`define PTM_PERIOD_RESET  16'hFFFF
`define PTM_COUNT_RESET   16'h0000
`define PTM_PS_DIV8_M1    8'h07
`define PTM_PS_DIV64_M1   8'h3F
`define PTM_PS_DIV256_M1  8'hFF

`endif

// ### src/ptm_pkg.sv
// Purpose: Types for the paired 32-bit timer.
// Assumes: Nothing beyond the params header.
// Notes:   Prescale codes map to divide ratios.
package ptm_pkg;
    typedef enum logic [1:0] {
        PTM_PS_1   = 2'b00,
        PTM_PS_8   = 2'b01,
        PTM_PS_64  = 2'b10,
        PTM_PS_256 = 2'b11
    } ptm_prescale_t;
endpackage : ptm_pkg

// ### src/ptm_prescaler.sv
// Purpose: Clock select, edge detect and prescale divider for one timer half.
// Assumes: External clock pin already synchronous to mclk.
// Notes:   Emits a one-cycle tick per prescaled input event.
`timescale 1ns/1ps
`include "ptm_params.svh"
module ptm_prescaler
    import ptm_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       resetn,
    input  wire logic       ce,
    input  wire logic       run,
    input  wire logic       ext_sel,
    input  wire logic       ext_clk,
    input  wire logic       sync_out,
    input  wire logic [1:0] ps_sel,
    input  wire logic       ps_clear,
    output logic            tick
);
    logic       ext_q;
    logic [7:0] cnt_q;
    logic       raw_q;
    logic       tick_q;
    ptm_prescale_t ps;
    logic [7:0] limit;
    wire        ext_rise = ext_clk & ~ext_q;
    wire        src_evt  = ext_sel ? ext_rise : 1'b1;
    wire        wrap     = (cnt_q == limit);
    wire        div_evt  = run & src_evt & wrap;

    // ****************************************
    // Divide ratio decode
    // ****************************************
    assign ps = ptm_prescale_t'(ps_sel);
    always_comb begin
        unique case (ps)
            PTM_PS_1:   limit = 8'h00;
            PTM_PS_8:   limit = `PTM_PS_DIV8_M1;
            PTM_PS_64:  limit = `PTM_PS_DIV64_M1;
            PTM_PS_256: limit = `PTM_PS_DIV256_M1;
        endcase
    end

    // Prescale counter; halted clock means clears are lost when off
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            cnt_q <= 8'h00;
            ext_q <= 1'b0;
        end else if (ce) begin
            ext_q <= ext_clk;
            if (ps_clear && run) begin
                cnt_q <= 8'h00;
            end else if (run && src_evt) begin
                cnt_q <= wrap ? 8'h00 : cnt_q + 8'h01;
            end
        end
    end

    // Optional resync stage on the divider output
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            raw_q  <= 1'b0;
            tick_q <= 1'b0;
        end else if (ce) begin
            raw_q  <= div_evt & ~ps_clear;
            tick_q <= raw_q;
        end
    end

    assign tick = sync_out ? tick_q : (div_evt & ~ps_clear);
endmodule : ptm_prescaler

// ### src/ptm_pair_timer.sv
// Purpose: Timer pair: two 16-bit timers or one 32-bit timer/counter.
// Assumes: Register strobes are one-cycle pulses synchronous to mclk.
// Notes:   The pin input is synchronous; no interrupt controller here.
//
// What this block does
// - Split halves run as 16-bit timers/counters
// - Combined count: low word, high word
// - Combined mode ignores high control word
// - Combined match sets high flag; interrupt enable-gated
// - Low half prescaler output resynchronised
// - 32-bit timer counts cycles, wraps on period
// - Low count read latches high hold
// - 32-bit counter counts synced external edges
// - Idle stop bit halts counting in idle
// - Gate mode counts cycles while pin high
// - High half gate setting ignored in combined mode
// - Gate fall stops count without clearing
// - Combined match emits converter trigger pulse
// - Prescale divides by 1, 8, 64, 256
// - Combined mode uses low prescaler only
// - Count or control writes clear prescaler
// - Disabled timer keeps prescaler uncleared
// - Control writes leave counts unchanged
// - 16-bit timer wraps on own period
// - No counting during sleep
// - Combined gate fall sets high flag
`timescale 1ns/1ps
`include "ptm_params.svh"
module ptm_pair_timer
    import ptm_pkg::*;
#(
    parameter int WIDTH = 16
) (
    input  wire logic             mclk,
    input  wire logic             resetn,
    input  wire logic             ce,
    input  wire logic             cpu_idle,
    input  wire logic             cpu_sleep,
    input  wire logic             gate_clock_pin,
    input  wire logic             high_clk_pin,
    input  wire logic [WIDTH-1:0] wr_data,
    input  wire logic             low_ctrl_wr,
    input  wire logic             high_ctrl_wr,
    input  wire logic             low_count_wr,
    input  wire logic             high_count_wr,
    input  wire logic             high_hold_wr,
    input  wire logic             period_low_wr,
    input  wire logic             period_high_wr,
    input  wire logic             low_count_rd,
    input  wire logic             low_irq_clr,
    input  wire logic             pair_irq_clr,
    input  wire logic             low_irq_enable,
    input  wire logic             pair_irq_enable,
    output logic [WIDTH-1:0]      low_count,
    output logic [WIDTH-1:0]      high_count,
    output logic [WIDTH-1:0]      high_hold,
    output logic [WIDTH-1:0]      low_ctrl,
    output logic [WIDTH-1:0]      high_ctrl,
    output logic                  low_irq_flag,
    output logic                  pair_irq_flag,
    output logic                  low_irq,
    output logic                  pair_irq,
    output logic                  adc_trigger
);
    // ****************************************
    // Elaboration checks
    // ****************************************
    if (WIDTH != 16) begin : g_bad_width
        $error("ptm_pair_timer supports WIDTH 16 only");
    end

    logic [WIDTH-1:0] low_count_q, high_count_q, high_hold_q;
    logic [WIDTH-1:0] period_low_q, period_high_q, low_ctrl_q, high_ctrl_q;
    logic             low_irq_q, pair_irq_q, low_irq_o_q, pair_irq_o_q, trig_q;
    logic             gate_q, high_pin_q;
    logic             low_tick, high_tick;

    // ****************************************
    // Control decode
    // ****************************************
    // combined mode select
    wire wide_mode_sel   = low_ctrl_q[`PTM_BIT_WIDE];
    wire low_on          = low_ctrl_q[`PTM_BIT_ON];
    wire low_gate        = low_ctrl_q[`PTM_BIT_GATE] & ~low_ctrl_q[`PTM_BIT_CLKSRC];
    wire high_on         = high_ctrl_q[`PTM_BIT_ON] & ~wide_mode_sel;
    wire high_gate       = high_ctrl_q[`PTM_BIT_GATE] & ~high_ctrl_q[`PTM_BIT_CLKSRC]
                           & ~wide_mode_sel;
    wire low_clk_ok      = ~cpu_sleep & ~(cpu_idle & low_ctrl_q[`PTM_BIT_IDLE_STOP]);
    wire high_clk_ok     = ~cpu_sleep & ~(cpu_idle & high_ctrl_q[`PTM_BIT_IDLE_STOP]);
    wire low_run         = low_on & low_clk_ok & (~low_gate | gate_clock_pin);
    wire high_run        = high_on & high_clk_ok & (~high_gate | high_clk_pin);
    wire low_ps_clr      = low_count_wr | low_ctrl_wr
                           | (wide_mode_sel & (high_count_wr | high_ctrl_wr));
    wire high_ps_clr     = high_count_wr | high_ctrl_wr;
    // Gate falling edge ends an accumulation window
    wire gate_fall       = low_on & low_gate & gate_q & ~gate_clock_pin;
    wire high_gate_fall  = high_on & high_gate & high_pin_q & ~high_clk_pin;

    // ****************************************
    // Prescalers
    // ****************************************
    // selectable divider per half
    ptm_prescaler u_low_ps (
        .mclk     (mclk),
        .resetn   (resetn),
        .ce       (ce),
        .run      (low_run),
        .ext_sel  (low_ctrl_q[`PTM_BIT_CLKSRC]),
        .ext_clk  (gate_clock_pin),
        .sync_out (1'b1),
        .ps_sel   (low_ctrl_q[`PTM_BIT_PS_HI:`PTM_BIT_PS_LO]),
        .ps_clear (low_ps_clr),
        .tick     (low_tick)
    );
    ptm_prescaler u_high_ps (
        .mclk     (mclk),
        .resetn   (resetn),
        .ce       (ce),
        .run      (high_run),
        .ext_sel  (high_ctrl_q[`PTM_BIT_CLKSRC]),
        .ext_clk  (high_clk_pin),
        .sync_out (1'b0),
        .ps_sel   (high_ctrl_q[`PTM_BIT_PS_HI:`PTM_BIT_PS_LO]),
        .ps_clear (high_ps_clr),
        .tick     (high_tick)
    );

    // ****************************************
    // Match and next-count logic
    // ****************************************
    // low word is least significant
    wire [2*WIDTH-1:0] cnt32   = {high_count_q, low_count_q};
    wire [2*WIDTH-1:0] per32   = {period_high_q, period_low_q};
    // same path for synced external edges
    wire match32     = wide_mode_sel & low_tick & (cnt32 == per32);
    // 16-bit each half on own period
    wire match_low   = ~wide_mode_sel & low_tick & (low_count_q == period_low_q);
    wire match_high  = ~wide_mode_sel & high_tick & (high_count_q == period_high_q);
    wire [2*WIDTH-1:0] cnt32_d = match32 ? '0 : cnt32 + 32'h0000_0001;
    // gate fall sets flag but keeps count
    // combined gate fall to high flag
    wire pair_evt    = wide_mode_sel ? (match32 | gate_fall) : (match_high | high_gate_fall);
    wire low_evt     = ~wide_mode_sel & (match_low | gate_fall);

    // Pin edge history for both gates; a level test alone would
    // raise the flag on every cycle that the pin sits low
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            gate_q     <= 1'b0;
            high_pin_q <= 1'b0;
        end else if (ce) begin
            gate_q     <= gate_clock_pin;
            high_pin_q <= high_clk_pin;
        end
    end

    // ****************************************
    // Control and period registers
    // ****************************************
    // control write touches no count
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            low_ctrl_q    <= `PTM_CTRL_RESET;
            high_ctrl_q   <= `PTM_CTRL_RESET;
            period_low_q  <= `PTM_PERIOD_RESET;
            period_high_q <= `PTM_PERIOD_RESET;
        end else if (ce) begin
            if (low_ctrl_wr)    low_ctrl_q    <= wr_data;
            if (high_ctrl_wr)   high_ctrl_q   <= wr_data;
            if (period_low_wr)  period_low_q  <= wr_data;
            if (period_high_wr) period_high_q <= wr_data;
        end
    end

    // ****************************************
    // Count registers and holding register
    // ****************************************
    // Software writes take priority over a count tick
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            low_count_q  <= `PTM_COUNT_RESET;
            high_count_q <= `PTM_COUNT_RESET;
            high_hold_q  <= `PTM_COUNT_RESET;
        end else if (ce) begin
            if (high_hold_wr) begin
                high_hold_q <= wr_data;
            end else if (low_count_rd) begin
                high_hold_q <= high_count_q;
            end
            if (low_count_wr) begin
                low_count_q <= wr_data;
            end else if (low_tick) begin
                low_count_q <= wide_mode_sel ? cnt32_d[WIDTH-1:0]
                             : (match_low ? '0 : low_count_q + 16'h0001);
            end
            // low write loads high from hold
            if (wide_mode_sel && low_count_wr) begin
                high_count_q <= high_hold_q;
            end else if (high_count_wr) begin
                high_count_q <= wr_data;
            end else if (wide_mode_sel && low_tick) begin
                high_count_q <= cnt32_d[2*WIDTH-1:WIDTH];
            end else if (!wide_mode_sel && high_tick) begin
                high_count_q <= match_high ? '0 : high_count_q + 16'h0001;
            end
        end
    end

    // ****************************************
    // Flags, interrupt lines and trigger
    // ****************************************
    // flag set wins over clear
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            low_irq_q    <= 1'b0;
            pair_irq_q   <= 1'b0;
            low_irq_o_q  <= 1'b0;
            pair_irq_o_q <= 1'b0;
            trig_q       <= 1'b0;
        end else if (ce) begin
            low_irq_q    <= low_evt | (low_irq_q & ~low_irq_clr);
            pair_irq_q   <= pair_evt | (pair_irq_q & ~pair_irq_clr);
            low_irq_o_q  <= low_irq_enable & (low_evt | (low_irq_q & ~low_irq_clr));
            pair_irq_o_q <= pair_irq_enable & (pair_evt | (pair_irq_q & ~pair_irq_clr));
            trig_q       <= match32;
        end
    end

    assign low_count     = low_count_q;
    assign high_count    = high_count_q;
    assign high_hold     = high_hold_q;
    assign low_ctrl      = low_ctrl_q;
    assign high_ctrl     = high_ctrl_q;
    assign low_irq_flag  = low_irq_q;
    assign pair_irq_flag = pair_irq_q;
    assign low_irq       = low_irq_o_q;
    assign pair_irq      = pair_irq_o_q;
    assign adc_trigger   = trig_q;

    // ****************************************
    // Assertions
    // ****************************************
    wrap_zero_a: assert property (@(posedge mclk) disable iff (!resetn)
        (ce && match32 && !low_count_wr && !high_count_wr) |=> ({high_count, low_count} == 32'h0))
        else $error("combined count did not wrap to zero");
    trig_pulse_a: assert property (@(posedge mclk) disable iff (!resetn)
        (ce && match32) |=> adc_trigger)
        else $error("trigger missing after match");
    trig_cause_a: assert property (@(posedge mclk) disable iff (!resetn)
        (adc_trigger && $past(ce)) |-> $past(match32))
        else $error("trigger without match");
    hold_latch_a: assert property (@(posedge mclk) disable iff (!resetn)
        (ce && low_count_rd && !high_hold_wr) |=> (high_hold == $past(high_count)))
        else $error("hold did not capture high word");
    hold_load_a: assert property (@(posedge mclk) disable iff (!resetn)
        (ce && wide_mode_sel && low_count_wr) |=> (high_count == $past(high_hold)))
        else $error("high word not loaded from hold");
    sleep_freeze_a: assert property (@(posedge mclk) disable iff (!resetn)
        (ce && cpu_sleep && $past(cpu_sleep) && $past(cpu_sleep, 2) && !low_count_wr
         && !high_count_wr && !high_hold_wr) |=> $stable(low_count))
        else $error("count moved during sleep");
    ctrl_keep_a: assert property (@(posedge mclk) disable iff (!resetn)
        (ce && low_ctrl_wr && !low_count_wr && !low_tick) |=> $stable(low_count))
        else $error("control write changed count");
    flag_sticky_a: assert property (@(posedge mclk) disable iff (!resetn)
        (ce && pair_irq_flag && !pair_irq_clr) |=> pair_irq_flag)
        else $error("flag dropped without clear");
    flag_gate_a: assert property (@(posedge mclk) disable iff (!resetn)
        (pair_irq && $past(ce)) |-> $past(pair_irq_enable))
        else $error("interrupt raised while disabled");

    // Idle, gate and split-half checks
    idle_freeze_a: assert property (@(posedge mclk) disable iff (!resetn)
        (ce && $past(ce) && $past(ce, 2) && $past(cpu_idle, 2)
         && $past(low_ctrl[`PTM_BIT_IDLE_STOP], 2) && !low_count_wr) |=> $stable(low_count))
        else $error("count moved during idle stop");
    gate_flag_a: assert property (@(posedge mclk) disable iff (!resetn)
        (ce && wide_mode_sel && gate_fall) |=> pair_irq_flag)
        else $error("gate fall did not set flag");
    high_fall_a: assert property (@(posedge mclk) disable iff (!resetn)
        (ce && high_gate_fall) |=> pair_irq_flag)
        else $error("split gate fall did not set flag");
    low_wrap_a: assert property (@(posedge mclk) disable iff (!resetn)
        (ce && match_low && !low_count_wr) |=> (low_count == 16'h0000))
        else $error("low half did not wrap to zero");
    high_wrap_a: assert property (@(posedge mclk) disable iff (!resetn)
        (ce && match_high && !high_count_wr) |=> (high_count == 16'h0000))
        else $error("high half did not wrap to zero");
    low_flag_a: assert property (@(posedge mclk) disable iff (!resetn)
        (ce && match_low) |=> low_irq_flag)
        else $error("low half match did not set flag");
endmodule : ptm_pair_timer

// ### test/ptm_pair_timer_tb_top.sv
// Purpose: Self-checking bench for the paired timer, driven through strobes.
// Assumes: Strobes are taken on the next rising mclk; outputs settle 1 ns later.
// Notes:   Rates are measured as deltas, so resync lag does not skew them.
`timescale 1ns/1ps
module ptm_pair_timer_tb_top
    import ptm_pkg::*;
;
    // ****************************************
    // Stimulus and observed signals
    // ****************************************
    localparam int w_lctl = 0, w_hctl = 1, w_lcnt = 2, w_hcnt = 3;
    localparam int w_hold = 4, w_perl = 5, w_perh = 6;
    logic        mclk = 1'b0, resetn = 1'b0, ce = 1'b1, cpu_idle = 1'b0, cpu_sleep = 1'b0;
    logic        gate_clock_pin = 1'b0, high_clk_pin = 1'b0;
    logic        low_irq_enable = 1'b0, pair_irq_enable = 1'b0;
    logic [15:0] wr_data = 16'h0000;
    logic [6:0]  wr_stb  = 7'h00;
    logic [2:0]  pls     = 3'h0; // Read, pair clear, low clear
    wire logic [15:0] low_count, high_count, high_hold, low_ctrl, high_ctrl;
    wire logic        low_irq_flag, pair_irq_flag, low_irq, pair_irq, adc_trigger;
    int          err_count = 0;
    int          compares  = 0;

    // Free-running 125 MHz clock
    always #4 mclk = ~mclk;

    ptm_pair_timer #(.WIDTH(16)) dut (
        .mclk(mclk), .resetn(resetn), .ce(ce), .cpu_idle(cpu_idle), .cpu_sleep(cpu_sleep),
        .gate_clock_pin(gate_clock_pin), .high_clk_pin(high_clk_pin), .wr_data(wr_data),
        .low_ctrl_wr(wr_stb[0]), .high_ctrl_wr(wr_stb[1]), .low_count_wr(wr_stb[2]),
        .high_count_wr(wr_stb[3]), .high_hold_wr(wr_stb[4]), .period_low_wr(wr_stb[5]),
        .period_high_wr(wr_stb[6]), .low_count_rd(pls[0]), .low_irq_clr(pls[2]),
        .pair_irq_clr(pls[1]), .low_irq_enable(low_irq_enable),
        .pair_irq_enable(pair_irq_enable), .low_count(low_count), .high_count(high_count),
        .high_hold(high_hold), .low_ctrl(low_ctrl), .high_ctrl(high_ctrl),
        .low_irq_flag(low_irq_flag), .pair_irq_flag(pair_irq_flag), .low_irq(low_irq),
        .pair_irq(pair_irq), .adc_trigger(adc_trigger));

    // ****************************************
    // Access and checking tasks
    // ****************************************
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : tick

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // One-cycle write strobe; lowered on the following edge
    task automatic wr_reg(input int sel, input logic [15:0] d);
        @(posedge mclk);
        wr_data     <= d;
        wr_stb[sel] <= 1'b1;
        @(posedge mclk);
        wr_stb      <= 7'h00;
    endtask : wr_reg

    task automatic pulse(input int sel);
        @(posedge mclk);
        pls[sel] <= 1'b1;
        @(posedge mclk);
        pls      <= 3'h0;
    endtask : pulse

    // Settle, then count increments over ten cycles; ends on an edge
    // so that the caller's next drive lands on a rising edge
    task automatic rate(input logic [15:0] exp);
        logic [15:0] v0;
        tick(4);
        v0 = low_count;
        tick(10);
        chk(low_count - v0, exp);
        @(posedge mclk);
    endtask : rate

    task automatic wrap_up();
        if (err_count == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : wrap_up

    // Timeouts count as a mismatch and end the run
    task automatic bail();
        err_count++;
        wrap_up();
    endtask : bail

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        int          i;
        int          divs[4];
        logic        seen;
        logic [15:0] v0;
        divs = '{1, 8, 64, 256};
        repeat (3) @(posedge mclk);
        resetn <= 1'b1;
        tick(1);
        chk(low_count, 16'h0000);
        chk({high_count | low_ctrl | high_ctrl}, 16'h0000);
        chk({14'h0, pair_irq_flag, adc_trigger}, 16'h0000);
        // carry into high word, coherent load, wrap on period
        wr_reg(w_perl, 16'h0000);
        wr_reg(w_perh, 16'h0001);
        wr_reg(w_lctl, 16'h0008);
        wr_reg(w_hold, 16'h0000);
        wr_reg(w_lcnt, 16'hFFFC);
        wr_reg(w_lctl, 16'h8008);
        seen = 1'b0;
        for (i = 0; i < 40 && adc_trigger !== 1'b1; i++) begin
            tick(1);
            if (high_count === 16'h0001 && low_count === 16'h0000) seen = 1'b1;
        end
        if (i == 40) bail();
        chk({15'h0, seen}, 16'h0001);
        chk({high_count, low_count} == 32'h0, 16'h0001);
        chk({14'h0, pair_irq_flag, low_irq_flag}, 16'h0002);
        chk({15'h0, pair_irq}, 16'h0000);
        tick(1);
        chk({15'h0, adc_trigger}, 16'h0000);
        // control write keeps counts; holding path
        wr_reg(w_lctl, 16'h0008);
        tick(1);
        v0 = low_count;
        wr_reg(w_lctl, 16'h0018);
        tick(1);
        chk(low_count, v0);
        wr_reg(w_hold, 16'h1234);
        wr_reg(w_lcnt, 16'h0000);
        tick(1);
        chk(high_count, 16'h1234);
        wr_reg(w_hold, 16'h0000);
        pulse(0);
        tick(1);
        chk(high_hold, 16'h1234);
        // every prescale code, with high half set to divide by 256
        wr_reg(w_perh, 16'hFFFF);
        wr_reg(w_perl, 16'hFFFF);
        wr_reg(w_hctl, 16'h8030);
        for (int k = 0; k < 4; k++) begin
            wr_reg(w_lctl, {1'b1, 9'h000, ptm_prescale_t'(k), 4'h8});
            tick(1);
            v0 = low_count;
            for (i = 0; i < 600 && low_count === v0; i++) tick(1);
            if (i == 600) bail();
            v0 = low_count;
            tick(2 * divs[k]);
            chk(low_count - v0, 16'h0002);
        end
        chk(high_ctrl, 16'h8030);
        wr_reg(w_lctl, 16'hA008);
        cpu_idle <= 1'b1;
        rate(16'h0000);
        cpu_idle <= 1'b0;
        rate(16'h000A);
        wr_reg(w_lctl, 16'h8008);
        cpu_idle <= 1'b1;
        rate(16'h000A);
        cpu_idle  <= 1'b0;
        cpu_sleep <= 1'b1;
        rate(16'h0000);
        cpu_sleep <= 1'b0;
        // gated accumulation, no clear, flag on fall
        wr_reg(w_lctl, 16'h0008);
        wr_reg(w_lcnt, 16'h0000);
        pulse(1);
        pair_irq_enable <= 1'b1;
        wr_reg(w_lctl, 16'h8048);
        tick(6);
        chk(low_count, 16'h0000);
        @(posedge mclk);
        gate_clock_pin <= 1'b1;
        repeat (20) @(posedge mclk);
        gate_clock_pin <= 1'b0;
        tick(6);
        chk(low_count, 16'h0014);
        chk({14'h0, pair_irq_flag, pair_irq}, 16'h0003);
        tick(10);
        chk(low_count, 16'h0014);
        pulse(1);
        tick(2);
        chk({14'h0, pair_irq_flag, pair_irq}, 16'h0000);
        // counter mode on external rising edges
        wr_reg(w_lctl, 16'h0008);
        wr_reg(w_lcnt, 16'h0000);
        wr_reg(w_lctl, 16'h800A);
        repeat (5) begin
            repeat (4) @(posedge mclk);
            gate_clock_pin <= 1'b1;
            repeat (4) @(posedge mclk);
            gate_clock_pin <= 1'b0;
        end
        tick(6);
        chk(low_count, 16'h0005);
        // split halves wrap on their own periods
        wr_reg(w_lctl, 16'h0000);
        wr_reg(w_perl, 16'h0003);
        wr_reg(w_perh, 16'h0005);
        wr_reg(w_lcnt, 16'h0000);
        wr_reg(w_hcnt, 16'h0000);
        low_irq_enable <= 1'b1;
        wr_reg(w_lctl, 16'h8000);
        wr_reg(w_hctl, 16'h8000);
        v0 = 16'h0000;
        wr_data <= 16'h0000;
        for (i = 0; i < 40; i++) begin
            tick(1);
            if (low_count > v0[7:0]) v0[7:0] = low_count[7:0];
            if (high_count > v0[15:8]) v0[15:8] = high_count[7:0];
        end
        chk(v0, 16'h0503);
        chk({14'h0, low_irq_flag, low_irq}, 16'h0003);
        // Split high half in gated mode flags only the falling edge
        wr_reg(w_hctl, 16'h8040);
        wr_reg(w_hcnt, 16'h0000);
        pulse(1);
        high_clk_pin <= 1'b1;
        repeat (3) @(posedge mclk);
        high_clk_pin <= 1'b0;
        tick(2);
        chk(high_count, 16'h0003);
        chk({15'h0, pair_irq_flag}, 16'h0001);
        pulse(1);
        tick(3);
        chk({15'h0, pair_irq_flag}, 16'h0000);
        wrap_up();
    end
endmodule : ptm_pair_timer_tb_top
